// ---- shared/nod_map.svh ----
// fixed values for the null-op and operand decoder
// assumes inclusion by bare name from the package and the decode core
`ifndef NOD_MAP_SVH
`define NOD_MAP_SVH

// high byte forced onto a direct-page address
`define NOD_DIRECT_PAGE_HIGH 8'h00
// value the program counter takes at reset
`define NOD_PC_RESET 16'h0000
// clear values for captured fields
`define NOD_BYTE_ZERO 8'h00
`define NOD_WORD_ZERO 16'h0000
`define NOD_IDX_ZERO 2'h0
// index of the first, second and third operand byte
`define NOD_IDX_FIRST 2'h0
`define NOD_IDX_SECOND 2'h1
`define NOD_IDX_THIRD 2'h2
// operand byte counts per format
`define NOD_LEN_NONE 2'h0
`define NOD_LEN_ONE 2'h1
`define NOD_LEN_TWO 2'h2
`define NOD_LEN_THREE 2'h3
// program counter step per accepted byte
`define NOD_PC_STEP 16'h0001

`endif

// ---- shared/nod_pkg.sv ----
// types shared by the null-op and operand decoder files
// assumes the map header sits in the include path
package nod_pkg;
    `include "nod_map.svh"

    // operand layout that follows an opcode
    typedef enum logic [3:0]
    {
        FMT_NONE = 4'b0000,
        FMT_DIRECT = 4'b0001,
        FMT_REL8 = 4'b0010,
        FMT_REL16 = 4'b0011,
        FMT_IDX9 = 4'b0100,
        FMT_IDX16 = 4'b0101,
        FMT_EXT = 4'b0110,
        FMT_IMM16 = 4'b0111,
        FMT_MASK = 4'b1000,
        FMT_PAGE_CALL = 4'b1001,
        FMT_LOOP9 = 4'b1010
    } nod_fmt_type;

    typedef enum logic [1:0]
    {
        ST_OPCODE = 2'b00,
        ST_OPERAND = 2'b01,
        ST_EXEC = 2'b10,
        ST_DEBUG = 2'b11
    } nod_state_type;
endpackage : nod_pkg

// ---- core/nod_word_pair.sv ----
// two-byte collector: high byte first, then low byte
// assumes at most one of the three controls per cycle
module nod_word_pair
#(
    parameter int BYTE_W = 8
)
(
    input wire logic clock, // core clock
    input wire logic reset, // async, active high
    input wire logic clear, // empty the word
    input wire logic take_high, // byte is the high half
    input wire logic take_low, // byte is the low half
    input wire logic [BYTE_W-1:0] byte_in, // stream byte
    output logic [2*BYTE_W-1:0] word_q // assembled word
);
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            word_q <= '0;
        else if (clear)
            word_q <= '0;
        else if (take_high)
            word_q[2*BYTE_W-1:BYTE_W] <= byte_in;
        else if (take_low)
            word_q[BYTE_W-1:0] <= byte_in;
    end
endmodule : nod_word_pair

// ---- core/nod_sign_ext.sv ----
// sign extension of a narrow offset to a wider word
// assumes OUT_W is larger than IN_W
module nod_sign_ext
#(
    parameter int IN_W = 8,
    parameter int OUT_W = 16
)
(
    input wire logic [IN_W-1:0] value_in, // signed narrow value
    output logic [OUT_W-1:0] value_out // sign-extended value
);
    assign value_out = {{(OUT_W-IN_W){value_in[IN_W-1]}}, value_in};
endmodule : nod_sign_ext

// ---- core/nod_decode.sv ----
// decode of debug entry, null operations and instruction operand bytes
// assumes program memory presents bytes in order at pc_q with a
// valid/ready handshake, and an opcode table supplies fmt_in with opcodes
`include "nod_map.svh"
module nod_decode
    import nod_pkg::*;
#(
    parameter logic [7:0] OP_ENTER_DEBUG = 8'h01, // arbitrary default
    parameter logic [7:0] OP_NOP = 8'h02, // arbitrary default
    parameter logic [7:0] OP_SHORT_BRN = 8'h03, // arbitrary default
    parameter logic [7:0] OP_LONG_BRN = 8'h04, // arbitrary default
    parameter int IDX_SIGN_POS = 0, // sign bit in indexed postbyte
    parameter int LOOP_SIGN_POS = 4 // sign bit in loop postbyte
)
(
    input wire logic clock, // core clock, 10 MHz
    input wire logic reset, // async, active high
    input wire logic fetch_valid, // stream byte present
    input wire logic [7:0] fetch_byte, // stream byte at pc_q
    output logic fetch_ready, // byte can be taken this cycle
    input wire nod_fmt_type fmt_in, // operand format of opcode byte
    input wire logic cond_true, // branch condition holds
    input wire logic debug_enable, // background debug allowed
    input wire logic debug_resume, // leave background debug
    input wire logic pc_load, // force program counter
    input wire logic [15:0] pc_load_value, // value to force
    input wire logic [7:0] bit_data, // operand of bit instruction
    input wire logic bit_set, // 1 sets, 0 clears masked bits
    output logic [15:0] pc_q, // program counter
    output logic op_done_q, // one-cycle end of instruction
    output logic [7:0] opcode_q, // opcode just decoded
    output logic null_op_q, // instruction writes no register
    output logic debug_active_q, // in background debug
    output logic branch_taken_q, // control was transferred
    output logic [15:0] target_q, // branch target
    output logic [15:0] ea_q, // effective or call address
    output logic [15:0] offset_q, // signed displacement
    output logic [15:0] imm_q, // immediate word
    output logic [7:0] mask_q, // bit select mask
    output logic [7:0] bit_result_q, // masked bit result
    output logic [7:0] page_q, // overlay page for call
    output logic [7:0] postbyte_q // indexed or loop postbyte
);
    nod_state_type state_q;
    nod_fmt_type fmt_q;
    logic [1:0] idx_q;
    logic [1:0] len_d;
    logic never_q;
    logic nop_like_q;
    logic accept;
    logic last_byte;
    logic take_high;
    logic take_low;
    logic [15:0] word;
    logic [15:0] rel8_ext;
    logic [15:0] idx9_ext;
    logic [15:0] loop9_ext;
    logic [15:0] off_d;
    logic branch_d;
    logic is_null_opcode;
    nod_fmt_type fmt_d;

    assign fetch_ready = (state_q == ST_OPCODE) || (state_q == ST_OPERAND);
    assign accept = fetch_valid && fetch_ready;

    // the null forms are recognised here, so a wrong table entry
    // cannot make them consume the wrong number of bytes
    always_comb
    begin
        fmt_d = fmt_in;
        is_null_opcode = 1'b0;
        if (fetch_byte == OP_NOP || fetch_byte == OP_ENTER_DEBUG)
        begin
            fmt_d = FMT_NONE;
            is_null_opcode = 1'b1;
        end
        else if (fetch_byte == OP_SHORT_BRN)
        begin
            fmt_d = FMT_REL8;
            is_null_opcode = 1'b1;
        end
        else if (fetch_byte == OP_LONG_BRN)
        begin
            fmt_d = FMT_REL16;
            is_null_opcode = 1'b1;
        end
    end

    always_comb
    begin
        case (fmt_d)
            FMT_NONE: len_d = `NOD_LEN_NONE;
            FMT_DIRECT: len_d = `NOD_LEN_ONE;
            FMT_REL8: len_d = `NOD_LEN_ONE;
            FMT_MASK: len_d = `NOD_LEN_ONE;
            FMT_IDX16: len_d = `NOD_LEN_THREE;
            FMT_PAGE_CALL: len_d = `NOD_LEN_THREE;
            default: len_d = `NOD_LEN_TWO;
        endcase
    end

    // last operand byte of the format held in fmt_q
    always_comb
    begin
        case (fmt_q)
            FMT_DIRECT: last_byte = (idx_q == `NOD_IDX_FIRST);
            FMT_REL8: last_byte = (idx_q == `NOD_IDX_FIRST);
            FMT_MASK: last_byte = (idx_q == `NOD_IDX_FIRST);
            FMT_IDX16: last_byte = (idx_q == `NOD_IDX_THIRD);
            FMT_PAGE_CALL: last_byte = (idx_q == `NOD_IDX_THIRD);
            default: last_byte = (idx_q == `NOD_IDX_SECOND);
        endcase
    end

    // which half of the operand word the current byte fills
    always_comb
    begin
        take_high = 1'b0;
        take_low = 1'b0;
        if (accept && state_q == ST_OPERAND)
        begin
            case (fmt_q)
                FMT_DIRECT, FMT_REL8, FMT_MASK:
                    take_low = 1'b1;
                FMT_REL16, FMT_EXT, FMT_IMM16:
                begin
                    take_high = (idx_q == `NOD_IDX_FIRST);
                    take_low = (idx_q == `NOD_IDX_SECOND);
                end
                FMT_IDX9, FMT_LOOP9:
                    take_low = (idx_q == `NOD_IDX_SECOND);
                FMT_IDX16:
                begin
                    take_high = (idx_q == `NOD_IDX_SECOND);
                    take_low = (idx_q == `NOD_IDX_THIRD);
                end
                FMT_PAGE_CALL:
                begin
                    take_high = (idx_q == `NOD_IDX_FIRST);
                    take_low = (idx_q == `NOD_IDX_SECOND);
                end
                default:
                begin
                    take_high = 1'b0;
                    take_low = 1'b0;
                end
            endcase
        end
    end

    nod_word_pair #(.BYTE_W(8)) u_word
    (
        .clock(clock),
        .reset(reset),
        .clear(accept && state_q == ST_OPCODE),
        .take_high(take_high),
        .take_low(take_low),
        .byte_in(fetch_byte),
        .word_q(word)
    );

    nod_sign_ext #(.IN_W(8), .OUT_W(16)) u_rel8
    (
        .value_in(word[7:0]),
        .value_out(rel8_ext)
    );

    nod_sign_ext #(.IN_W(9), .OUT_W(16)) u_idx9
    (
        .value_in({postbyte_q[IDX_SIGN_POS], word[7:0]}),
        .value_out(idx9_ext)
    );

    nod_sign_ext #(.IN_W(9), .OUT_W(16)) u_loop9
    (
        .value_in({postbyte_q[LOOP_SIGN_POS], word[7:0]}),
        .value_out(loop9_ext)
    );

    always_comb
    begin
        case (fmt_q)
            FMT_REL8: off_d = rel8_ext;
            FMT_REL16: off_d = word;
            FMT_IDX9: off_d = idx9_ext;
            FMT_IDX16: off_d = word;
            FMT_LOOP9: off_d = loop9_ext;
            default: off_d = `NOD_WORD_ZERO;
        endcase
    end

    // condition codes are never looked at for the never forms
    assign branch_d = !never_q && cond_true
        && (fmt_q == FMT_REL8 || fmt_q == FMT_REL16 || fmt_q == FMT_LOOP9);

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            state_q <= ST_OPCODE;
        else
        begin
            case (state_q)
                ST_OPCODE:
                    if (accept)
                    begin
                        if (fetch_byte == OP_ENTER_DEBUG && debug_enable)
                            state_q <= ST_DEBUG;
                        else if (len_d == `NOD_LEN_NONE)
                            state_q <= ST_EXEC;
                        else
                            state_q <= ST_OPERAND;
                    end
                ST_OPERAND:
                    if (accept && last_byte)
                        state_q <= ST_EXEC;
                ST_EXEC:
                    state_q <= ST_OPCODE;
                ST_DEBUG:
                    if (debug_resume)
                        state_q <= ST_OPCODE;
                default:
                    state_q <= ST_OPCODE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            fmt_q <= FMT_NONE;
            opcode_q <= `NOD_BYTE_ZERO;
            never_q <= 1'b0;
            nop_like_q <= 1'b0;
        end
        else if (accept && state_q == ST_OPCODE)
        begin
            fmt_q <= fmt_d;
            opcode_q <= fetch_byte;
            never_q <= (fetch_byte == OP_SHORT_BRN)
                || (fetch_byte == OP_LONG_BRN);
            nop_like_q <= is_null_opcode;
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            idx_q <= `NOD_IDX_ZERO;
        else if (accept && state_q == ST_OPCODE)
            idx_q <= `NOD_IDX_ZERO;
        else if (accept)
            idx_q <= idx_q + 2'h1;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            postbyte_q <= `NOD_BYTE_ZERO;
            page_q <= `NOD_BYTE_ZERO;
        end
        else if (accept && state_q == ST_OPERAND)
        begin
            if (idx_q == `NOD_IDX_FIRST
                && (fmt_q == FMT_IDX9 || fmt_q == FMT_IDX16
                || fmt_q == FMT_LOOP9))
                postbyte_q <= fetch_byte;
            if (idx_q == `NOD_IDX_THIRD && fmt_q == FMT_PAGE_CALL)
                page_q <= fetch_byte;
        end
    end

    // the program counter is the only result a null op alters
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            pc_q <= `NOD_PC_RESET;
        else if (pc_load)
            pc_q <= pc_load_value;
        else if (accept)
            pc_q <= pc_q + `NOD_PC_STEP;
        else if (state_q == ST_EXEC && branch_d)
            pc_q <= pc_q + off_d;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            debug_active_q <= 1'b0;
        else if (state_q == ST_DEBUG && debug_resume)
            debug_active_q <= 1'b0;
        else if (accept && state_q == ST_OPCODE
            && fetch_byte == OP_ENTER_DEBUG && debug_enable)
            debug_active_q <= 1'b1;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            op_done_q <= 1'b0;
            null_op_q <= 1'b0;
            branch_taken_q <= 1'b0;
        end
        else
        begin
            op_done_q <= (state_q == ST_EXEC);
            null_op_q <= (state_q == ST_EXEC) && nop_like_q;
            branch_taken_q <= (state_q == ST_EXEC) && branch_d;
        end
    end

    // operand outputs here update only at exec of a non-null op, so a null op leaves them
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            target_q <= `NOD_WORD_ZERO;
            offset_q <= `NOD_WORD_ZERO;
            ea_q <= `NOD_WORD_ZERO;
            imm_q <= `NOD_WORD_ZERO;
            mask_q <= `NOD_BYTE_ZERO;
            bit_result_q <= `NOD_BYTE_ZERO;
        end
        else if (state_q == ST_EXEC && !nop_like_q)
        begin
            offset_q <= off_d;
            target_q <= pc_q + off_d;
            case (fmt_q)
                FMT_DIRECT:
                    ea_q <= {`NOD_DIRECT_PAGE_HIGH, word[7:0]};
                FMT_EXT, FMT_PAGE_CALL:
                    ea_q <= word;
                FMT_IMM16:
                    imm_q <= word;
                FMT_MASK:
                begin
                    mask_q <= word[7:0];
                    if (bit_set)
                        bit_result_q <= bit_data | word[7:0];
                    else
                        bit_result_q <= bit_data & ~word[7:0];
                end
                default:
                    ea_q <= ea_q;
            endcase
        end
    end
endmodule : nod_decode

// ---- bench/nod_prog_mem.sv ----
// program memory model offering the byte stream at pc_q
// assumes the bench fills mem and opens a fetch window per test
module nod_prog_mem
(
    input wire logic clock, // core clock
    input wire logic reset, // async, active high
    input wire logic [15:0] pc_q, // fetch address
    input wire logic fetch_ready, // byte can be taken
    input wire logic [15:0] win_base, // first fetchable address
    input wire logic [2:0] win_len, // bytes in window
    input wire logic slow, // one wait cycle per byte
    output logic fetch_valid, // byte present
    output logic [7:0] fetch_byte // byte at pc_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    logic wait_q;
    logic in_win;

    initial
    begin
        for (int a = 0; a < 65536; a++)
            mem[a] = 8'h5A;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            wait_q <= 1'b0;
        else
            wait_q <= slow && fetch_valid && fetch_ready;
    end

    assign in_win = (pc_q - win_base) < {13'h0000, win_len};
    assign fetch_valid = in_win && !wait_q;
    // nothing offered: inverse so a stale byte cannot pass as good
    assign fetch_byte = fetch_valid ? mem[pc_q] : ~mem[pc_q];
endmodule : nod_prog_mem

// ---- bench/nod_decode_properties.sv ----
// port assertions for the null-op and operand decoder
// assumes one clock and an async active-high reset
module nod_decode_checker
(
    input wire logic clock, // core clock
    input wire logic reset, // async, active high
    input wire logic fetch_valid, // byte offered
    input wire logic fetch_ready, // byte can be taken
    input wire logic pc_load, // pc forced
    input wire logic [15:0] pc_q, // program counter
    input wire logic op_done_q, // end of instruction
    input wire logic null_op_q, // null op ended
    input wire logic debug_active_q, // in debug
    input wire logic branch_taken_q, // branch done
    input wire logic [15:0] target_q, // branch target
    input wire logic [15:0] offset_q, // displacement
    input wire logic [15:0] ea_q // effective address
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    property p_pc_step;
        fetch_valid && fetch_ready && !pc_load
            |=> pc_q == $past(pc_q) + 16'h0001;
    endproperty
    a_pc_step: assert property (p_pc_step)
        else $error("pc did not step on a taken byte");
    property p_done_after_exec;
        op_done_q |-> !$past(fetch_ready);
    endproperty
    a_done_after_exec: assert property (p_done_after_exec)
        else $error("no exec cycle before op done");
    property p_done_pulse;
        op_done_q |=> !op_done_q;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("op done longer than one cycle");
    property p_null_kind;
        null_op_q |-> op_done_q && !branch_taken_q;
    endproperty
    a_null_kind: assert property (p_null_kind)
        else $error("null op branched or lacks op done");
    property p_null_hold;
        null_op_q |-> $stable(target_q) && $stable(offset_q) && $stable(ea_q);
    endproperty
    a_null_hold: assert property (p_null_hold)
        else $error("null op changed a result");
    property p_taken_pc;
        branch_taken_q |-> pc_q == target_q;
    endproperty
    a_taken_pc: assert property (p_taken_pc)
        else $error("taken branch pc differs from target");
    property p_debug_stall;
        debug_active_q |-> !fetch_ready && !op_done_q;
    endproperty
    a_debug_stall: assert property (p_debug_stall)
        else $error("fetch or op done while in debug");
    property p_debug_pc;
        debug_active_q && !pc_load |=> $stable(pc_q);
    endproperty
    a_debug_pc: assert property (p_debug_pc)
        else $error("pc moved while in debug");

    c_taken: cover property (branch_taken_q);
    c_null: cover property (null_op_q);
    c_debug: cover property ($rose(debug_active_q));
endmodule : nod_decode_checker

bind nod_decode nod_decode_checker i_chk
(
    .clock(clock), .reset(reset), .fetch_valid(fetch_valid),
    .fetch_ready(fetch_ready), .pc_load(pc_load), .pc_q(pc_q),
    .op_done_q(op_done_q), .null_op_q(null_op_q),
    .debug_active_q(debug_active_q), .branch_taken_q(branch_taken_q),
    .target_q(target_q), .offset_q(offset_q), .ea_q(ea_q)
);

// ---- bench/tb_nod_decode.sv ----
// self-checking bench for the null-op and operand decoder
// assumes default opcode parameters and the memory model
module tb_nod_decode
    import nod_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed
    {
        logic [31:0] code; // opcode in the top byte
        logic [2:0] len;
        nod_fmt_type fmt;
        logic flag; // branch condition and bit_set
        logic [2:0] sel; // output compared
        logic [15:0] exp; // offset when sel is the target
        logic nul;
        logic tkn;
    } nod_row_type;

    nod_row_type rows [18] = '{
        '{32'h02000000, 3'h1, FMT_NONE, 1'b0, 3'h2, 16'h0000, 1'b1, 1'b0},
        '{32'h20800000, 3'h2, FMT_REL8, 1'b1, 3'h0, 16'hFF80, 1'b0, 1'b1},
        '{32'h207F0000, 3'h2, FMT_REL8, 1'b0, 3'h2, 16'h007F, 1'b0, 1'b0},
        '{32'h03100000, 3'h2, FMT_REL8, 1'b1, 3'h2, 16'h007F, 1'b1, 1'b0},
        '{32'h21FF0000, 3'h3, FMT_REL16, 1'b1, 3'h0, 16'hFF00, 1'b0, 1'b1},
        '{32'h04123400, 3'h3, FMT_REL16, 1'b1, 3'h2, 16'hFF00, 1'b1, 1'b0},
        '{32'h30A50000, 3'h2, FMT_DIRECT, 1'b0, 3'h1, 16'h00A5, 1'b0, 1'b0},
        '{32'h31123400, 3'h3, FMT_EXT, 1'b0, 3'h1, 16'h1234, 1'b0, 1'b0},
        '{32'h32ABCD00, 3'h3, FMT_IMM16, 1'b0, 3'h3, 16'hABCD, 1'b0, 1'b0},
        '{32'h33011000, 3'h3, FMT_IDX9, 1'b0, 3'h2, 16'hFF10, 1'b0, 1'b0},
        '{32'h33FE1000, 3'h3, FMT_IDX9, 1'b0, 3'h2, 16'h0010, 1'b0, 1'b0},
        '{32'h3400EEFF, 3'h4, FMT_IDX16, 1'b0, 3'h2, 16'hEEFF, 1'b0, 1'b0},
        '{32'h35100000, 3'h3, FMT_LOOP9, 1'b0, 3'h2, 16'hFF00, 1'b0, 1'b0},
        '{32'h35EF8000, 3'h3, FMT_LOOP9, 1'b0, 3'h2, 16'h0080, 1'b0, 1'b0},
        '{32'h360F0000, 3'h2, FMT_MASK, 1'b1, 3'h4, 16'h00AF, 1'b0, 1'b0},
        '{32'h360F0000, 3'h2, FMT_MASK, 1'b0, 3'h4, 16'h00A0, 1'b0, 1'b0},
        '{32'h3712345A, 3'h4, FMT_PAGE_CALL, 1'b0, 3'h5, 16'h005A, 1'b0, 1'b0},
        '{32'h01000000, 3'h1, FMT_NONE, 1'b0, 3'h2, 16'h0000, 1'b1, 1'b0}
    };

    logic clock, reset, fetch_valid, fetch_ready, cond_true, debug_enable;
    logic debug_resume, pc_load, bit_set, op_done_q, null_op_q, slow;
    logic debug_active_q, branch_taken_q;
    logic [7:0] fetch_byte, bit_data, opcode_q, mask_q, bit_result_q;
    logic [7:0] page_q, postbyte_q;
    logic [15:0] pc_load_value, pc_q, target_q, ea_q, offset_q, imm_q;
    logic [15:0] win_base, b, e, x;
    logic [2:0] win_len;
    nod_fmt_type fmt_in;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    nod_decode i_dut
    (
        .clock(clock), .reset(reset), .fetch_valid(fetch_valid),
        .fetch_byte(fetch_byte), .fetch_ready(fetch_ready),
        .fmt_in(fmt_in), .cond_true(cond_true),
        .debug_enable(debug_enable), .debug_resume(debug_resume),
        .pc_load(pc_load), .pc_load_value(pc_load_value),
        .bit_data(bit_data), .bit_set(bit_set), .pc_q(pc_q),
        .op_done_q(op_done_q), .opcode_q(opcode_q), .null_op_q(null_op_q),
        .debug_active_q(debug_active_q), .branch_taken_q(branch_taken_q),
        .target_q(target_q), .ea_q(ea_q), .offset_q(offset_q),
        .imm_q(imm_q), .mask_q(mask_q), .bit_result_q(bit_result_q),
        .page_q(page_q), .postbyte_q(postbyte_q)
    );

    nod_prog_mem i_mem
    (
        .clock(clock), .reset(reset), .pc_q(pc_q),
        .fetch_ready(fetch_ready), .win_base(win_base),
        .win_len(win_len), .slow(slow), .fetch_valid(fetch_valid),
        .fetch_byte(fetch_byte)
    );

    always #50 clock = ~clock;

    task automatic tally_and_finish();
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // generous ceiling: whole run needs about a hundred cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic chk(input string n, input logic [15:0] ex,
        input logic [15:0] g);
        n_compared++;
        if (g !== ex)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, ex, g);
        end
    endtask : chk

    function automatic logic [15:0] pick(input logic [2:0] s);
        case (s)
            3'h0: pick = target_q;
            3'h1: pick = ea_q;
            3'h2: pick = offset_q;
            3'h3: pick = imm_q;
            3'h4: pick = {8'h00, bit_result_q};
            default: pick = {8'h00, page_q};
        endcase
    endfunction : pick

    // called at a falling edge; window opens once pc is loaded
    task automatic start(input logic [15:0] base, input logic [2:0] n);
        win_base = base;
        win_len = n;
        pc_load = 1'b1;
        pc_load_value = base;
        @(negedge clock);
        pc_load = 1'b0;
    endtask : start

    task automatic wait_done();
        int k;
        k = 0;
        @(negedge clock);
        while (op_done_q !== 1'b1 && k < 30)
        begin
            @(negedge clock);
            k++;
        end
        chk("op_done_q", 16'h0001, {15'h0000, op_done_q});
    endtask : wait_done

    initial
    begin
        clock = 1'b0;
        reset = 1'b1;
        cond_true = 1'b0;
        debug_enable = 1'b0;
        debug_resume = 1'b0;
        pc_load = 1'b0;
        pc_load_value = 16'h0000;
        bit_data = 8'hA5;
        bit_set = 1'b0;
        fmt_in = FMT_NONE;
        win_base = 16'h0000;
        win_len = 3'h0;
        slow = 1'b0;
        repeat (3) @(negedge clock);
        reset = 1'b0;
        chk("pc_q", 16'h0000, pc_q);
        chk("fetch_ready", 16'h0001, {15'h0000, fetch_ready});
        for (int i = 0; i < 18; i++)
        begin
            b = 16'(i + 1) << 10;
            for (int j = 0; j < 4; j++)
                i_mem.mem[b + 16'(j)] = rows[i].code[31 - 8 * j -: 8];
            fmt_in = rows[i].fmt;
            cond_true = rows[i].flag;
            bit_set = rows[i].flag;
            start(b, rows[i].len);
            wait_done();
            e = b + {13'h0000, rows[i].len};
            x = rows[i].sel == 3'h0 ? e + rows[i].exp : rows[i].exp;
            chk("pc_q", rows[i].tkn ? e + rows[i].exp : e, pc_q);
            chk("null_op_q", {15'h0000, rows[i].nul}, null_op_q);
            chk("taken", {15'h0000, rows[i].tkn}, branch_taken_q);
            chk("result", x, pick(rows[i].sel));
            chk("opcode", 16'(rows[i].code[31:24]), 16'(opcode_q));
        end
        // last mask, postbyte and call address survive the null row
        chk("mask_q", 16'h000F, {8'h00, mask_q});
        chk("postbyte_q", 16'h00EF, {8'h00, postbyte_q});
        chk("ea_q", 16'h1234, ea_q);
        i_mem.mem[16'hA000] = 8'h01;
        debug_enable = 1'b1;
        start(16'hA000, 3'h1);
        repeat (4) @(negedge clock);
        chk("debug_active_q", 16'h0001, {15'h0000, debug_active_q});
        chk("fetch_ready", 16'h0000, {15'h0000, fetch_ready});
        chk("pc_q", 16'hA001, pc_q);
        debug_resume = 1'b1;
        @(negedge clock);
        debug_resume = 1'b0;
        @(negedge clock);
        chk("debug_active_q", 16'h0000, {15'h0000, debug_active_q});
        debug_enable = 1'b0;
        slow = 1'b1;
        fmt_in = FMT_EXT;
        i_mem.mem[16'hC000] = 8'h02;
        i_mem.mem[16'hC001] = 8'h31;
        i_mem.mem[16'hC002] = 8'h56;
        i_mem.mem[16'hC003] = 8'h78;
        start(16'hC000, 3'h4);
        wait_done();
        wait_done();
        chk("ea_q", 16'h5678, ea_q);
        chk("pc_q", 16'hC004, pc_q);
        tally_and_finish();
    end
endmodule : tb_nod_decode
